// *** timer_regs_pkg.sv ***
package timer_regs_pkg;
   // Register port geometry
   localparam int ADDR_W = 10;
   localparam int DATA_W = 4;

   // Register offsets; load and counter nibbles share an address
   localparam logic [ADDR_W-1:0] TIMER_A_MODE_ADDR  = 10'h008;
   localparam logic [ADDR_W-1:0] TIMER_B_MODE_ADDR  = 10'h009;
   localparam logic [ADDR_W-1:0] TIMER_B_LOW_ADDR   = 10'h00a;
   localparam logic [ADDR_W-1:0] TIMER_B_HIGH_ADDR  = 10'h00b;
   localparam logic [ADDR_W-1:0] TIMER_C_MODE_ADDR  = 10'h00d;
   localparam logic [ADDR_W-1:0] TIMER_C_LOW_ADDR   = 10'h00e;
   localparam logic [ADDR_W-1:0] TIMER_C_HIGH_ADDR  = 10'h00f;

   // Reset values, read-back zero and counter maximum
   localparam logic [3:0] MODE_RESET  = 4'h0;
   localparam logic [7:0] LOAD_RESET  = 8'h00;
   localparam logic [7:0] COUNT_RESET = 8'h00;
   localparam logic [3:0] READ_ZERO   = 4'h0;
   localparam logic [7:0] COUNT_MAX   = 8'hff;

   // Mode register fields
   localparam int MODE_TOP_BIT = 3;   // Source (A) or auto-reload (B, C)
   localparam logic [2:0] TA_SUB_FORBIDDEN = 3'h5;
   localparam logic [2:0] TA_SUB_HOLD      = 3'h6;
   localparam logic [2:0] TA_SUB_HALF      = 3'h4;
   localparam logic [2:0] TB_EXT_EVENT     = 3'h7;

   // Prescaler widths: system in instruction cycles, sub in half sub-cycles
   localparam int SYS_PRESCALER_W = 11;
   localparam int SUB_PRESCALER_W = 6;

   typedef enum logic [1:0] {
      MODE_INTERVAL,
      MODE_TIMEBASE,
      MODE_IDLE,
      MODE_HELD
   } timer_a_op_t;

   // System prescaler bit whose fall marks the period (timers A and C)
   function automatic logic [3:0] tap_ac(input logic [2:0] code);
      logic [3:0] t;
      t = 4'h0;
      case (code)
         3'h0: t = 4'ha;   // 2048
         3'h1: t = 4'h9;   // 1024
         3'h2: t = 4'h8;   // 512
         3'h3: t = 4'h6;   // 128
         3'h4: t = 4'h4;   // 32
         3'h5: t = 4'h2;   // 8
         3'h6: t = 4'h1;   // 4
         default: t = 4'h0; // 2
      endcase
      return t;
   endfunction

   // System prescaler tap for timer B
   function automatic logic [3:0] tap_b(input logic [2:0] code);
      logic [3:0] t;
      t = 4'h0;
      case (code)
         3'h0: t = 4'ha;   // 2048
         3'h1: t = 4'h8;   // 512
         3'h2: t = 4'h6;   // 128
         3'h3: t = 4'h4;   // 32
         3'h4: t = 4'h2;   // 8
         3'h5: t = 4'h1;   // 4
         default: t = 4'h0; // 2
      endcase
      return t;
   endfunction

   // Sub prescaler tap; counts are half sub-cycles
   function automatic logic [2:0] tap_sub(input logic [2:0] code);
      logic [2:0] t;
      t = 3'h0;
      case (code)
         3'h0: t = 3'h5;   // 32 sub-cycles
         3'h1: t = 3'h4;   // 16
         3'h2: t = 3'h3;   // 8
         default: t = 3'h1; // 2
      endcase
      return t;
   endfunction
endpackage

// *** three_timer_mode_and_load_regs.sv ***
// Decided for this implementation: strobed register access.
`timescale 1ns/1ns
`default_nettype none
module three_timer_mode_and_load_regs
   import timer_regs_pkg::*;
(
   input  wire logic                                  core_clk,
   input  wire logic                                  reset,
   input  wire logic [timer_regs_pkg::ADDR_W-1:0]     reg_addr,
   input  wire logic [timer_regs_pkg::DATA_W-1:0]     reg_wdata,
   input  wire logic                                  reg_write,
   input  wire logic                                  reg_read,
   output logic      [timer_regs_pkg::DATA_W-1:0]     reg_rdata,
   input  wire logic [timer_regs_pkg::SYS_PRESCALER_W-1:0]
                                                      system_clock_prescaler,
   input  wire logic [timer_regs_pkg::SUB_PRESCALER_W-1:0]
                                                      subclock_prescaler,
   input  wire logic                                  external_event,
   input  wire logic                                  display_running,
   output logic                                       subclock_prescaler_reset,
   output logic                                       display_power_off,
   output logic                                       timer_a_irq_flag,
   output logic                                       timer_b_irq_flag,
   output logic                                       timer_c_irq_flag,
   output logic                                       timer_c_pulse_out
);
   import timer_regs_pkg::*;

   // Register decode strobes
   logic wr_a_mode;
   logic wr_b_mode;
   logic wr_c_mode;
   logic wr_b_low;
   logic wr_b_high;
   logic wr_c_low;
   logic wr_c_high;
   logic rd_b_high;
   logic rd_c_high;

   // Mode registers, staged one cycle so a write acts two cycles later
   logic [3:0] timer_a_mode_reg;
   logic [3:0] timer_b_mode_reg;
   logic [3:0] timer_c_mode_reg;
   logic [3:0] mode_a_pend;
   logic [3:0] mode_b_pend;
   logic [3:0] mode_c_pend;
   logic       pend_a;
   logic       pend_b;
   logic       pend_c;

   // Load registers, counters and read captures
   logic [3:0] timer_b_reload_low;
   logic [3:0] timer_b_reload_high;
   logic [3:0] timer_c_reload_low;
   logic [3:0] timer_c_reload_high;
   logic [7:0] timer_a_counter;
   logic [7:0] count_b;
   logic [7:0] count_c;
   logic [3:0] capture_b_low;
   logic [3:0] capture_c_low;

   // Input clock edge detection state
   logic [SYS_PRESCALER_W-1:0] sys_prev;
   logic [SUB_PRESCALER_W-1:0] sub_prev;
   logic                       event_prev;

   // Pulse output shadow settings
   logic [7:0] pulse_threshold;
   logic       pulse_toggle_mode;
   logic       pulse_toggle;

   timer_a_op_t a_op;
   logic        tick_a;
   logic        tick_b;
   logic        tick_c;
   logic        sub_step;

   // Write and read decode over the plain register port
   always_comb begin
      wr_a_mode = 1'b0;
      wr_b_mode = 1'b0;
      wr_c_mode = 1'b0;
      wr_b_low  = 1'b0;
      wr_b_high = 1'b0;
      wr_c_low  = 1'b0;
      wr_c_high = 1'b0;
      if (reg_write) begin
         if (reg_addr == TIMER_A_MODE_ADDR) begin
            wr_a_mode = 1'b1;
         end else if (reg_addr == TIMER_B_MODE_ADDR) begin
            wr_b_mode = 1'b1;
         end else if (reg_addr == TIMER_B_LOW_ADDR) begin
            wr_b_low = 1'b1;
         end else if (reg_addr == TIMER_B_HIGH_ADDR) begin
            wr_b_high = 1'b1;
         end else if (reg_addr == TIMER_C_MODE_ADDR) begin
            wr_c_mode = 1'b1;
         end else if (reg_addr == TIMER_C_LOW_ADDR) begin
            wr_c_low = 1'b1;
         end else if (reg_addr == TIMER_C_HIGH_ADDR) begin
            wr_c_high = 1'b1;
         end
      end
   end

   assign rd_b_high = reg_read && (reg_addr == TIMER_B_HIGH_ADDR);
   assign rd_c_high = reg_read && (reg_addr == TIMER_C_HIGH_ADDR);

   // Mode writes land in a stage, then apply on the following edge
   always_ff @(posedge core_clk or posedge reset) begin
      if (reset) begin
         mode_a_pend      <= MODE_RESET;
         mode_b_pend      <= MODE_RESET;
         mode_c_pend      <= MODE_RESET;
         pend_a           <= 1'b0;
         pend_b           <= 1'b0;
         pend_c           <= 1'b0;
         timer_a_mode_reg <= MODE_RESET;
         timer_b_mode_reg <= MODE_RESET;
         timer_c_mode_reg <= MODE_RESET;
      end else begin
         pend_a <= wr_a_mode;
         pend_b <= wr_b_mode;
         pend_c <= wr_c_mode;
         if (wr_a_mode) begin
            mode_a_pend <= reg_wdata;
         end
         if (wr_b_mode) begin
            mode_b_pend <= reg_wdata;
         end
         if (wr_c_mode) begin
            mode_c_pend <= reg_wdata;
         end
         if (pend_a) begin
            timer_a_mode_reg <= mode_a_pend;
         end
         if (pend_b) begin
            timer_b_mode_reg <= mode_b_pend;
         end
         if (pend_c) begin
            timer_c_mode_reg <= mode_c_pend;
         end
      end
   end

   // Previous prescaler values; a falling tap bit is one input period
   always_ff @(posedge core_clk or posedge reset) begin
      if (reset) begin
         sys_prev   <= '0;
         sub_prev   <= '0;
         event_prev <= 1'b0;
      end else begin
         sys_prev   <= system_clock_prescaler;
         sub_prev   <= subclock_prescaler;
         event_prev <= external_event;
      end
   end

   // Timer A operating mode from its mode register
   always_comb begin
      a_op = MODE_INTERVAL;
      if (timer_a_mode_reg[MODE_TOP_BIT]) begin
         if (timer_a_mode_reg[2:0] == TA_SUB_HOLD) begin
            a_op = MODE_HELD;
         end else if (timer_a_mode_reg[2:0] > TA_SUB_HALF) begin
            a_op = MODE_IDLE; // Forbidden or unlisted code: no counting
         end else begin
            a_op = MODE_TIMEBASE;
         end
      end
   end

   // Input clock selection for each counter
   always_comb begin
      sub_step = 1'b0;
      if (timer_a_mode_reg[2:0] == TA_SUB_HALF) begin
         sub_step = sub_prev[0] != subclock_prescaler[0];
      end else begin
         sub_step = sub_prev[tap_sub(timer_a_mode_reg[2:0])]
                    && !subclock_prescaler[tap_sub(timer_a_mode_reg[2:0])];
      end
      tick_a = 1'b0;
      case (a_op)
         MODE_INTERVAL: tick_a = sys_prev[tap_ac(timer_a_mode_reg[2:0])]
            && !system_clock_prescaler[tap_ac(timer_a_mode_reg[2:0])];
         MODE_TIMEBASE: tick_a = sub_step;
         default: tick_a = 1'b0;
      endcase
      // Event input counts rising edges; caller masks its interrupt
      if (timer_b_mode_reg[2:0] == TB_EXT_EVENT) begin
         tick_b = external_event && !event_prev;
      end else begin
         tick_b = sys_prev[tap_b(timer_b_mode_reg[2:0])]
                  && !system_clock_prescaler[tap_b(timer_b_mode_reg[2:0])];
      end
      tick_c = sys_prev[tap_ac(timer_c_mode_reg[2:0])]
               && !system_clock_prescaler[tap_ac(timer_c_mode_reg[2:0])];
   end

   // Timer A counter; held at zero by the hold code
   always_ff @(posedge core_clk or posedge reset) begin
      if (reset) begin
         timer_a_counter  <= COUNT_RESET;
         timer_a_irq_flag <= 1'b0;
      end else begin
         timer_a_irq_flag <= tick_a && (timer_a_counter == COUNT_MAX);
         if (a_op == MODE_HELD) begin
            timer_a_counter <= COUNT_RESET;
         end else if (tick_a) begin
            timer_a_counter <= timer_a_counter + 8'h01;
         end
      end
   end

   // Sub prescaler hold and display shutdown follow timer A mode
   always_ff @(posedge core_clk or posedge reset) begin
      if (reset) begin
         subclock_prescaler_reset <= 1'b0;
         display_power_off        <= 1'b0;
      end else begin
         subclock_prescaler_reset <= a_op == MODE_HELD;
         // Level, so the cut lasts only while display_running is high and the selection stands
         display_power_off <= display_running
                              && timer_a_mode_reg[MODE_TOP_BIT];
      end
   end

   // Load registers: nibble writes; reads elsewhere never touch them
   always_ff @(posedge core_clk or posedge reset) begin
      if (reset) begin
         timer_b_reload_low  <= LOAD_RESET[3:0];
         timer_b_reload_high <= LOAD_RESET[7:4];
         timer_c_reload_low  <= LOAD_RESET[3:0];
         timer_c_reload_high <= LOAD_RESET[7:4];
      end else begin
         if (wr_b_low) begin
            timer_b_reload_low <= reg_wdata;
         end
         if (wr_b_high) begin
            timer_b_reload_high <= reg_wdata;
         end
         if (wr_c_low) begin
            timer_c_reload_low <= reg_wdata;
         end
         if (wr_c_high) begin
            timer_c_reload_high <= reg_wdata;
         end
      end
   end

   // Timer B counter; a high nibble write wins over a same-cycle tick
   always_ff @(posedge core_clk or posedge reset) begin
      if (reset) begin
         count_b          <= COUNT_RESET;
         timer_b_irq_flag <= 1'b0;
      end else begin
         timer_b_irq_flag <= tick_b && (count_b == COUNT_MAX);
         if (wr_b_high) begin
            count_b <= {reg_wdata, timer_b_reload_low};
         end else if (tick_b && (count_b == COUNT_MAX)) begin
            count_b <= timer_b_mode_reg[MODE_TOP_BIT]
                       ? {timer_b_reload_high, timer_b_reload_low}
                       : COUNT_RESET;
         end else if (tick_b) begin
            count_b <= count_b + 8'h01;
         end
      end
   end

   // Timer C counter, same scheme as timer B
   always_ff @(posedge core_clk or posedge reset) begin
      if (reset) begin
         count_c          <= COUNT_RESET;
         timer_c_irq_flag <= 1'b0;
      end else begin
         timer_c_irq_flag <= tick_c && (count_c == COUNT_MAX);
         if (wr_c_high) begin
            count_c <= {reg_wdata, timer_c_reload_low};
         end else if (tick_c && (count_c == COUNT_MAX)) begin
            count_c <= timer_c_mode_reg[MODE_TOP_BIT]
                       ? {timer_c_reload_high, timer_c_reload_low}
                       : COUNT_RESET;
         end else if (tick_c) begin
            count_c <= count_c + 8'h01;
         end
      end
   end

   // Low nibble capture at the high read; counting does not disturb it
   always_ff @(posedge core_clk or posedge reset) begin
      if (reset) begin
         capture_b_low <= COUNT_RESET[3:0];
         capture_c_low <= COUNT_RESET[3:0];
      end else begin
         if (rd_b_high) begin
            capture_b_low <= count_b[3:0];
         end
         if (rd_c_high) begin
            capture_c_low <= count_c[3:0];
         end
      end
   end

   // Read data one cycle after the strobe; write-only reads give zero
   always_ff @(posedge core_clk or posedge reset) begin
      if (reset) begin
         reg_rdata <= READ_ZERO;
      end else if (!reg_read) begin
         reg_rdata <= READ_ZERO;
      end else if (reg_addr == TIMER_B_LOW_ADDR) begin
         reg_rdata <= capture_b_low;
      end else if (reg_addr == TIMER_B_HIGH_ADDR) begin
         reg_rdata <= count_b[7:4];
      end else if (reg_addr == TIMER_C_LOW_ADDR) begin
         reg_rdata <= capture_c_low;
      end else if (reg_addr == TIMER_C_HIGH_ADDR) begin
         reg_rdata <= count_c[7:4];
      end else begin
         reg_rdata <= READ_ZERO;
      end
   end

   // Pulse settings copied only at overflow, so a mid-period load
   // distorts at most the period it lands in
   always_ff @(posedge core_clk or posedge reset) begin
      if (reset) begin
         pulse_threshold   <= LOAD_RESET;
         pulse_toggle_mode <= 1'b0;
         pulse_toggle      <= 1'b0;
      end else if (tick_c && (count_c == COUNT_MAX)) begin
         pulse_threshold   <= {timer_c_reload_high, timer_c_reload_low};
         pulse_toggle_mode <= timer_c_mode_reg[MODE_TOP_BIT];
         pulse_toggle      <= !pulse_toggle;
      end
   end

   // Reload mode toggles per overflow; free-run mode compares the count
   always_ff @(posedge core_clk or posedge reset) begin
      if (reset) begin
         timer_c_pulse_out <= 1'b0;
      end else if (pulse_toggle_mode) begin
         timer_c_pulse_out <= pulse_toggle;
      end else begin
         timer_c_pulse_out <= count_c < pulse_threshold;
      end
   end
endmodule
`default_nettype wire

// *** three_timer_mode_and_load_regs_sva.sv ***
`timescale 1ns/1ns
`default_nettype none
module three_timer_mode_and_load_regs_sva
   import timer_regs_pkg::*;
(
   input wire logic                              core_clk,
   input wire logic                              reset,
   input wire logic [timer_regs_pkg::ADDR_W-1:0] reg_addr,
   input wire logic [timer_regs_pkg::DATA_W-1:0] reg_wdata,
   input wire logic                              reg_write,
   input wire logic                              reg_read,
   input wire logic [timer_regs_pkg::DATA_W-1:0] reg_rdata,
   input wire logic                              display_running,
   input wire logic                              subclock_prescaler_reset,
   input wire logic                              display_power_off,
   input wire logic                              timer_a_irq_flag,
   input wire logic                              timer_c_irq_flag
);
   import timer_regs_pkg::*;
   logic [3:0] shadow_mode_a;
   logic [2:0] mode_age;
   logic [8:0] irq_gap;
   logic       a_wr;
   default clocking @(posedge core_clk); endclocking
   default disable iff (reset);
   assign a_wr = reg_write && reg_addr == TIMER_A_MODE_ADDR;
   // Shadow of timer A mode; age lets the mode settle before judging
   always_ff @(posedge core_clk or posedge reset) begin
      if (reset) begin
         shadow_mode_a <= 4'h0;
         mode_age      <= 3'h0;
      end else if (a_wr) begin
         shadow_mode_a <= reg_wdata;
         mode_age      <= 3'h0;
      end else if (mode_age != 3'h7) begin
         mode_age <= mode_age + 3'h1;
      end
   end
   // Cycles since the last timer A overflow, saturating
   always_ff @(posedge core_clk or posedge reset) begin
      if (reset) irq_gap <= 9'h000;
      else if (timer_a_irq_flag) irq_gap <= 9'h000;
      else if (irq_gap != 9'h1ff) irq_gap <= irq_gap + 9'h001;
   end
   a_rdata_idle_zero: assert property (!$past(reg_read)
      |-> reg_rdata == 4'h0) else $error("read data not zero outside a read");
   a_mode_read_zero: assert property (reg_read
      && (reg_addr == TIMER_A_MODE_ADDR || reg_addr == TIMER_B_MODE_ADDR
      || reg_addr == TIMER_C_MODE_ADDR) |=> reg_rdata == 4'h0)
      else $error("write-only mode register read back data");
   a_unmapped_read_zero: assert property (reg_read
      && reg_addr == 10'h00c |=> reg_rdata == 4'h0)
      else $error("unmapped read not zero");
   a_hold_code_set: assert property (a_wr && reg_wdata == 4'he
      |-> ##[1:4] subclock_prescaler_reset) else $error("hold not raised");
   a_hold_code_clear: assert property (a_wr && reg_wdata != 4'he
      |-> ##[1:4] !subclock_prescaler_reset) else $error("hold not dropped");
   a_hold_no_count: assert property (subclock_prescaler_reset &&
      $past(subclock_prescaler_reset) |-> !timer_a_irq_flag)
      else $error("timer A overflow while held");
   a_display_stop: assert property (mode_age >= 3'h4
      && shadow_mode_a[3] && $past(display_running) |-> display_power_off)
      else $error("display power not cut in sub-clock mode");
   a_display_keep: assert property ((!$past(display_running) ||
      (mode_age >= 3'h4 && !shadow_mode_a[3])) |-> !display_power_off)
      else $error("display power cut without cause");
   a_overflow_spacing: assert property (timer_a_irq_flag
      |-> irq_gap >= 9'h0ff) else $error("timer A overflow too early");
   a_irq_c_single: assert property (timer_c_irq_flag
      |=> !timer_c_irq_flag)
      else $error("timer C overflow pulse longer than one cycle");
   c_hold_seen: cover property (subclock_prescaler_reset);
   c_power_cut: cover property (display_power_off);
   c_overflow_a: cover property (timer_a_irq_flag);
endmodule
bind three_timer_mode_and_load_regs three_timer_mode_and_load_regs_sva
   three_timer_mode_and_load_regs_sva_i (.core_clk(core_clk), .reset(reset),
   .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_write(reg_write),
   .reg_read(reg_read), .reg_rdata(reg_rdata),
   .display_running(display_running),
   .subclock_prescaler_reset(subclock_prescaler_reset),
   .display_power_off(display_power_off),
   .timer_a_irq_flag(timer_a_irq_flag), .timer_c_irq_flag(timer_c_irq_flag));
`default_nettype wire

// *** three_timer_mode_and_load_regs_tb_top.sv ***
`timescale 1ns/1ns
`default_nettype none
module three_timer_mode_and_load_regs_tb_top;
   import timer_regs_pkg::*;
   logic                 core_clk = 1'b0, reset = 1'b1;
   logic [ADDR_W-1:0]    reg_addr = '0;
   logic [DATA_W-1:0]    reg_wdata = '0, reg_rdata;
   logic                 reg_write = 1'b0, reg_read = 1'b0, rd_flag = 1'b0;
   logic [10:0]          sys_ps = '0;
   logic [5:0]           sub_ps = '0;
   logic                 ext_ev, disp = 1'b0, ext_man = 1'b0;
   logic                 ev_rand = 1'b0, ev_man = 1'b0;
   logic                 hold, pwr_off, irq_a, irq_b, irq_c, pulse, p1;
   logic [31:0]          seed = 32'h4877;
   logic [7:0]           exp_q[$];
   int                   n_irq[3] = '{0, 0, 0};
   int                   a_base = 0;
   int                   bad_count = 0, samples_checked = 0, cycles = 0;
   // Divider taps as bit positions: timers A and C, timer B, sub prescaler
   int                   tap_ac_t[8] = '{10, 9, 8, 6, 4, 2, 1, 0};
   int                   tap_b_t[7] = '{10, 8, 6, 4, 2, 1, 0};
   int                   tap_s_t[5] = '{5, 4, 3, 1, 0};
   always #4 core_clk = ~core_clk;
   // One driver for the event line: random until the event test owns it
   assign ext_ev = ext_man ? ev_man : ev_rand;
   three_timer_mode_and_load_regs three_timer_mode_and_load_regs_i (
      .core_clk(core_clk), .reset(reset), .reg_addr(reg_addr),
      .reg_wdata(reg_wdata), .reg_write(reg_write), .reg_read(reg_read),
      .reg_rdata(reg_rdata), .system_clock_prescaler(sys_ps),
      .subclock_prescaler(sub_ps), .external_event(ext_ev),
      .display_running(disp), .subclock_prescaler_reset(hold),
      .display_power_off(pwr_off), .timer_a_irq_flag(irq_a),
      .timer_b_irq_flag(irq_b), .timer_c_irq_flag(irq_c),
      .timer_c_pulse_out(pulse));
   function automatic logic [31:0] xs(input logic [31:0] s);
      s = s ^ (s << 13);
      s = s ^ (s >> 17);
      return s ^ (s << 5);
   endfunction
   task automatic check(input logic [7:0] seen, input logic [7:0] expv);
      samples_checked++;
      if (seen !== expv) begin
         bad_count++;
         $display("wrong value at %0t: saw %h expected %h", $time, seen,
                  expv);
      end
   endtask
   task automatic end_of_test();
      $display("checked %0d, mismatches %0d", samples_checked, bad_count);
      if (bad_count == 0 && samples_checked > 0) begin
         $display("verification passed");
      end else begin
         $display("verification failed");
      end
      $finish;
   endtask
   // Random display state and event line; the event goes manual for its test
   always @(posedge core_clk) begin
      seed <= xs(seed);
      disp <= seed[0];
      ev_rand <= seed[1];
      cycles++;
      if (cycles == 20000) begin
         bad_count++;
         end_of_test();
      end
   end
   // Counting at the falling edge keeps clear of the driver's updates
   always @(negedge core_clk) begin
      if (irq_a === 1'b1) n_irq[0]++;
      if (irq_b === 1'b1) n_irq[1]++;
      if (irq_c === 1'b1) n_irq[2]++;
      if (rd_flag) check({4'h0, reg_rdata}, exp_q.pop_front());
      rd_flag = reg_read;
   end
   task automatic cyc(input int n);
      repeat (n) @(posedge core_clk);
   endtask
   task automatic wr(input logic [ADDR_W-1:0] a, input logic [3:0] d);
      @(posedge core_clk);
      reg_addr <= a;
      reg_wdata <= d;
      reg_write <= 1'b1;
      @(posedge core_clk);
      reg_write <= 1'b0;
   endtask
   task automatic rd(input logic [ADDR_W-1:0] a, input logic [3:0] e);
      @(posedge core_clk);
      reg_addr <= a;
      reg_read <= 1'b1;
      exp_q.push_back({4'h0, e});
      @(posedge core_clk);
      reg_read <= 1'b0;
   endtask
   // One toggle per cycle of the chosen prescaler bits or the event line
   task automatic tog(input int sel, input logic [10:0] m, input int n);
      repeat (n) begin
         @(posedge core_clk);
         if (sel == 0) sys_ps <= sys_ps ^ m;
         else if (sel == 1) sub_ps <= sub_ps ^ m[5:0];
         else ev_man <= ~ev_man;
      end
   endtask
   // Overflow must come on the last toggle, not one before
   task automatic run(input int sel, input logic [10:0] m, input int nt,
                      input logic [2:0] chk);
      int base[3];
      base = n_irq;
      tog(sel, m, nt - 1);
      cyc(2);
      for (int i = 0; i < 3; i++) begin
         if (chk[i]) check(8'(n_irq[i] - base[i]), 8'h00);
      end
      tog(sel, m, 1);
      cyc(4);
      for (int i = 0; i < 3; i++) begin
         if (chk[i]) check(8'(n_irq[i]-base[i]), 8'h01);
      end
   endtask
   initial begin
      cyc(8);
      reset <= 1'b0;
      rd(TIMER_B_HIGH_ADDR, 4'h0);
      rd(TIMER_C_HIGH_ADDR, 4'h0);
      $display("test reset values done");
      // Timer B reloads the reset load value, so each run ends back at zero
      for (int c = 0; c < 7; c++) begin
         wr(TIMER_B_MODE_ADDR, {1'b1, 3'(c)});
         cyc(3);
         run(0, 11'h001 << tap_b_t[c], 512, 3'b010);
      end
      $display("test timer B ratios done");
      for (int c = 0; c < 8; c++) begin
         wr(TIMER_A_MODE_ADDR, {1'b0, 3'(c)});
         wr(TIMER_C_MODE_ADDR, {1'b0, 3'(c)});
         cyc(3);
         run(0, 11'h001 << tap_ac_t[c], 512, 3'b101);
      end
      $display("test timer A and C ratios done");
      // Ratio changes only via interval mode; overflow period stays long
      for (int c = 0; c < 5; c++) begin
         wr(TIMER_A_MODE_ADDR, 4'h0);
         wr(TIMER_A_MODE_ADDR, {1'b1, 3'(c)});
         cyc(3);
         run(1, 11'h001 << tap_s_t[c], (c == 4) ? 256 : 512, 3'b001);
      end
      wr(TIMER_A_MODE_ADDR, 4'he);
      cyc(3);
      a_base = n_irq[0];
      tog(1, 11'h001, 600);
      cyc(4);
      check(8'(n_irq[0]), 8'(a_base));
      check({7'h0, hold}, 8'h01);
      wr(TIMER_A_MODE_ADDR, 4'h0);
      cyc(3);
      check({7'h0, hold}, 8'h00);
      $display("test time base done");
      wr(TIMER_B_MODE_ADDR, 4'hc);
      wr(TIMER_C_MODE_ADDR, 4'hc);
      cyc(3);
      wr(TIMER_B_LOW_ADDR, 4'he);
      wr(TIMER_B_HIGH_ADDR, 4'hf);
      wr(TIMER_C_LOW_ADDR, 4'hf);
      wr(TIMER_C_HIGH_ADDR, 4'hf);
      rd(TIMER_B_HIGH_ADDR, 4'hf);
      wr(TIMER_B_LOW_ADDR, 4'h3);
      rd(TIMER_B_LOW_ADDR, 4'he);
      rd(TIMER_C_HIGH_ADDR, 4'hf);
      rd(TIMER_C_LOW_ADDR, 4'hf);
      rd(TIMER_B_MODE_ADDR, 4'h0);
      wr(10'h00c, 4'h5);
      rd(10'h00c, 4'h0);
      tog(0, 11'h004, 4);
      cyc(4);
      rd(TIMER_B_HIGH_ADDR, 4'hf);
      rd(TIMER_B_LOW_ADDR, 4'h3);
      tog(0, 11'h010, 2);
      cyc(4);
      @(negedge core_clk) p1 = pulse;
      tog(0, 11'h010, 2);
      cyc(4);
      @(negedge core_clk) check({7'h0, pulse}, {7'h0, ~p1});
      rd(TIMER_C_LOW_ADDR, 4'hf);
      $display("test load and capture done");
      ext_man <= 1'b1;
      ev_man <= 1'b0;
      wr(TIMER_B_MODE_ADDR, 4'h7);
      cyc(3);
      wr(TIMER_B_LOW_ADDR, 4'h0);
      wr(TIMER_B_HIGH_ADDR, 4'h0);
      run(2, 11'h001, 511, 3'b010);
      $display("test external event done");
      end_of_test();
   end
endmodule
`default_nettype wire
